/* verilog/tbm_defs.vh */
// Behaviour
// RQ1 - Last-page table read address is 111b over the low table pointer.
// RQ2 - Current-page read takes bits 10..8 from the high table pointer.
// RQ3 - Low byte goes to the named data location, high byte to latch.
// RQ4 - Table high latch reads back but ignores every program write.
// RQ5 - Each table read, either kind, completes in exactly two cycles.
// RQ6 - Reset pin low suspends the core and hands both pins to programmer.
// RQ7 - Program words move both ways on one serial data pin, external clock.
// RQ8 - Data memory is one bank of bytes, addresses 00 to FF.
// RQ9 - Unused data locations read zero and store nothing.
// RQ10 - Single-bit set and clear work except on protected bits.
// RQ11 - Every general-purpose location is readable and writable.
// RQ12 - Read-only special registers ignore writes, others accept them.
// RQ13 - Data memory is reachable through the memory pointer.
// RQ14 - Low and high table pointers supply low and high address parts.
// RQ15 - Unused bits of the loaded high byte read as zero.
// RQ16 - Indirect port accesses the location the pointer names.
// RQ17 - Fetched table word is 16 bits, low byte 7..0, high 15..8.
`ifndef TBM_DEFS_VH
`define TBM_DEFS_VH

// ***************************************************
// Data memory map
// ***************************************************
`define TBM_ADDR_INDIRECT 8'h00
`define TBM_ADDR_MEM_PTR 8'h01
`define TBM_ADDR_TBL_PTR_LOW 8'h07
`define TBM_ADDR_TBL_HIGH_LATCH 8'h08
`define TBM_ADDR_TBL_PTR_HIGH 8'h1F
`define TBM_GP_FIRST 8'h30
`define TBM_GP_LAST 8'hFF
`define TBM_GP_DEPTH 208

// ***************************************************
// Reset values and widths
// ***************************************************
`define TBM_RST_BYTE 8'h00
`define TBM_RST_WORD 16'h0000
`define TBM_LAST_PAGE 3'h7
`define TBM_PAGE_MASK 8'h07
`define TBM_HIGH_USED_MASK 8'hFF

// ***************************************************
// Programming frame: direction, 11 address bits, 16 data bits
// ***************************************************
`define TBM_FRAME_HDR_BITS 5'd12
`define TBM_FRAME_ALL_BITS 5'd28
`define TBM_FIFO_WIDTH 27
`define TBM_FIFO_DEPTH 16
`define TBM_FIFO_AW 4

`endif

/* verilog/tbm_fifo.v */
`timescale 1ns/100ps
`default_nettype none
`include "tbm_defs.vh"

module tbm_fifo #(
  parameter WIDTH = `TBM_FIFO_WIDTH,
  parameter DEPTH = `TBM_FIFO_DEPTH,
  parameter AW = `TBM_FIFO_AW
) (
  input wire sys_clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  reg out_full;
  wire [AW:0] count;
  wire push;
  wire pop;
  wire load_out;

  // ***************************************************
  // Occupancy and handshakes
  // ***************************************************
  assign count = wr_ptr - rd_ptr;
  assign in_ready = (count != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign out_valid = out_full;
  assign pop = out_full && out_ready;
  // Output register refills whenever it is empty or being drained
  assign load_out = (count != {(AW+1){1'b0}}) && (!out_full || pop);

  // Storage array, no reset so it maps onto plain RAM
  always @(posedge sys_clk)
  begin
    if (push)
      store[wr_ptr[AW-1:0]] <= in_data;
  end

  // Pointers and registered read data
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (load_out)
      begin
        out_data <= store[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_full <= 1'b1;
      end
      else if (pop)
        out_full <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* verilog/tbm_table_mem.v */
`timescale 1ns/100ps
`default_nettype none
`include "tbm_defs.vh"

module tbm_table_mem (
  input wire sys_clk,
  input wire reset,
  // Core data memory port
  input wire [7:0] dm_addr,
  input wire dm_rd,
  input wire dm_wr,
  input wire [7:0] dm_wdata,
  input wire dm_bit_set,
  input wire dm_bit_clr,
  input wire [2:0] dm_bit_sel,
  output reg [7:0] dm_rdata,
  // Core table read port
  input wire tab_start,
  input wire tab_last_page,
  input wire [7:0] tab_dest,
  output wire tab_busy,
  output reg tab_done,
  // Program memory port
  output reg [10:0] pm_addr,
  input wire [15:0] pm_rdata,
  output wire pm_prog_wr,
  output wire [10:0] pm_prog_addr,
  output wire [15:0] pm_prog_data,
  input wire pm_prog_ready,
  // Programming pins
  input wire external_reset_n,
  input wire prog_clock_pin,
  input wire prog_data_pin_in,
  output reg prog_data_pin_out,
  output reg prog_data_pin_oe,
  output reg prog_mode,
  output wire prog_busy
);

  localparam T_IDLE = 3'b001;
  localparam T_FETCH = 3'b010;
  localparam T_STORE = 3'b100;

  reg [7:0] gp_ram [0:`TBM_GP_DEPTH-1];
  reg [7:0] memory_pointer;
  reg [7:0] table_pointer_low;
  reg [2:0] table_pointer_high;
  reg [7:0] table_high_latch;
  reg [2:0] tab_state;
  reg [7:0] tab_target;
  reg [2:0] rst_sync;
  reg [2:0] clk_sync;
  reg [2:0] dat_sync;
  reg rst_stable;
  reg clk_stable;
  reg [4:0] bit_count;
  reg [27:0] shift_in;
  reg [15:0] shift_out;
  reg [1:0] pread_stage;
  reg push_pending;
  wire core_en;
  wire clk_rise;
  wire clk_fall;
  wire fifo_ready;
  wire [26:0] fifo_out;
  wire [7:0] eff_addr;
  reg [7:0] cur_byte;
  wire [7:0] bit_mask;
  wire tab_write;
  wire [7:0] wr_addr;
  wire [7:0] wr_byte;
  wire any_write;

  // ***************************************************
  // Address and map helpers
  // ***************************************************
  // Indirect port resolves through the pointer; self-reference is null
  function [7:0] resolve;
    input [7:0] a;
    input [7:0] ptr;
    begin
      resolve = (a == `TBM_ADDR_INDIRECT) ? ptr : a; // [RQ13] [RQ16]
    end
  endfunction

  function is_gp;
    input [7:0] a;
    begin
      is_gp = (a >= `TBM_GP_FIRST); // [RQ11]
    end
  endfunction

  function [7:0] gp_index;
    input [7:0] a;
    begin
      gp_index = a - `TBM_GP_FIRST;
    end
  endfunction

  // ***************************************************
  // Pin synchronisers: three stages; reset and clock change when stages 2 and 3 agree
  // ***************************************************
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rst_sync <= 3'b111;
      clk_sync <= 3'b000;
      dat_sync <= 3'b000;
      rst_stable <= 1'b1;
      clk_stable <= 1'b0;
    end
    else
    begin
      rst_sync <= {rst_sync[1:0], external_reset_n};
      clk_sync <= {clk_sync[1:0], prog_clock_pin};
      dat_sync <= {dat_sync[1:0], prog_data_pin_in};
      if (rst_sync[1] == rst_sync[2])
        rst_stable <= rst_sync[2];
      if (clk_sync[1] == clk_sync[2])
        clk_stable <= clk_sync[2];
    end
  end

  assign clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_stable;
  assign clk_fall = (clk_sync[1] == clk_sync[2]) && !clk_sync[2] && clk_stable;
  // Core requests are honoured only outside programming
  assign core_en = !prog_mode; // [RQ6]

  // ***************************************************
  // Data memory access
  // ***************************************************
  assign eff_addr = resolve(dm_addr, memory_pointer);
  // Read mux as a process, so a register update with the address held
  // still reaches it; holes read zero
  always @*
  begin
    case (eff_addr)
      `TBM_ADDR_MEM_PTR: cur_byte = memory_pointer;
      `TBM_ADDR_TBL_PTR_LOW: cur_byte = table_pointer_low;
      `TBM_ADDR_TBL_HIGH_LATCH: cur_byte = table_high_latch;
      `TBM_ADDR_TBL_PTR_HIGH: cur_byte = {5'h00, table_pointer_high};
      default: cur_byte = is_gp(eff_addr) ?
        gp_ram[gp_index(eff_addr)] : `TBM_RST_BYTE; // [RQ9]
    endcase
  end

  assign bit_mask = 8'h01 << dm_bit_sel;
  assign tab_write = (tab_state == T_STORE);
  // Table store wins the write path; the core is stalled by tab_busy
  assign wr_addr = tab_write ? tab_target : eff_addr;
  assign wr_byte = tab_write ? pm_rdata[7:0] : // [RQ3] [RQ17]
                   dm_bit_set ? (cur_byte | bit_mask) : // [RQ10]
                   dm_bit_clr ? (cur_byte & ~bit_mask) : dm_wdata;
  assign any_write = tab_write ||
    (core_en && !tab_busy && (dm_wr || dm_bit_set || dm_bit_clr));

  // General-purpose bytes, no reset as in a real RAM
  always @(posedge sys_clk)
  begin
    if (any_write && is_gp(wr_addr))
      gp_ram[gp_index(wr_addr)] <= wr_byte; // [RQ8] [RQ11]
  end

  // Special registers; the latch has no program write path [RQ4]
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      memory_pointer <= `TBM_RST_BYTE;
      table_pointer_low <= `TBM_RST_BYTE;
      table_pointer_high <= 3'h0;
      dm_rdata <= `TBM_RST_BYTE;
    end
    else
    begin
      if (any_write)
      begin
        case (wr_addr)
          `TBM_ADDR_MEM_PTR: memory_pointer <= wr_byte; // [RQ12]
          `TBM_ADDR_TBL_PTR_LOW: table_pointer_low <= wr_byte; // [RQ14]
          `TBM_ADDR_TBL_PTR_HIGH:
            table_pointer_high <= wr_byte[2:0]; // [RQ14]
          default: ;
        endcase
      end
      if (dm_rd && core_en && !tab_busy)
        dm_rdata <= cur_byte; // [RQ9] [RQ16]
    end
  end

  // ***************************************************
  // Table read sequencer: start, fetch, store
  // ***************************************************
  assign tab_busy = (tab_state != T_IDLE);

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tab_state <= T_IDLE;
      tab_target <= `TBM_RST_BYTE;
      table_high_latch <= `TBM_RST_BYTE;
      tab_done <= 1'b0;
      pm_addr <= 11'h000;
      pread_stage <= 2'b00;
    end
    else
    begin
      tab_done <= 1'b0;
      pread_stage <= {pread_stage[0], 1'b0};
      case (tab_state)
        T_IDLE:
        begin
          if (tab_start && core_en)
          begin
            // Page bits from the high pointer or forced to the last page
            pm_addr <= {tab_last_page ? `TBM_LAST_PAGE : // [RQ1]
                        table_pointer_high, // [RQ2]
                        table_pointer_low}; // [RQ14]
            tab_target <= resolve(tab_dest, memory_pointer);
            tab_state <= T_FETCH;
          end
          else if (prog_mode && bit_count == `TBM_FRAME_HDR_BITS &&
                   shift_in[11] && clk_rise == 1'b0 &&
                   pread_stage == 2'b00 && !prog_data_pin_oe)
          begin
            pm_addr <= shift_in[10:0]; // [RQ7]
            pread_stage <= 2'b01;
          end
        end
        T_FETCH:
          tab_state <= T_STORE;
        T_STORE:
        begin
          // High byte always lands in the latch, unused bits zero
          table_high_latch <= pm_rdata[15:8] &
                              `TBM_HIGH_USED_MASK; // [RQ3] [RQ15] [RQ17]
          tab_done <= 1'b1; // [RQ5]
          tab_state <= T_IDLE;
        end
        default:
          tab_state <= T_IDLE;
      endcase
    end
  end

  // ***************************************************
  // Programming link: frames shifted on the programmer's clock
  // ***************************************************
  // Frame gets stuck until the FIFO takes it, so a full FIFO stalls
  assign prog_busy = push_pending;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prog_mode <= 1'b0;
      bit_count <= 5'd0;
      shift_in <= 28'h000_0000;
      shift_out <= `TBM_RST_WORD;
      prog_data_pin_out <= 1'b0;
      prog_data_pin_oe <= 1'b0;
      push_pending <= 1'b0;
    end
    else
    begin
      prog_mode <= !rst_stable; // [RQ6]
      if (push_pending && fifo_ready)
        push_pending <= 1'b0;
      if (!prog_mode)
      begin
        bit_count <= 5'd0;
        prog_data_pin_oe <= 1'b0; // [RQ6]
      end
      else if (pread_stage[1])
      begin
        // Read word arrives two cycles after its address
        shift_out <= {pm_rdata[14:0], 1'b0};
        prog_data_pin_out <= pm_rdata[15]; // [RQ7]
        prog_data_pin_oe <= 1'b1;
      end
      else if (prog_data_pin_oe)
      begin
        // Header's last fall lands after bit 15 is loaded; it must not shift
        if (clk_fall && bit_count != `TBM_FRAME_HDR_BITS)
        begin
          prog_data_pin_out <= shift_out[15];
          shift_out <= {shift_out[14:0], 1'b0};
        end
        if (clk_rise)
        begin
          bit_count <= bit_count + 5'd1;
          if (bit_count == `TBM_FRAME_ALL_BITS - 5'd1)
          begin
            bit_count <= 5'd0;
            prog_data_pin_oe <= 1'b0;
          end
        end
      end
      else if (clk_rise && !push_pending)
      begin
        shift_in <= {shift_in[26:0], dat_sync[2]}; // [RQ7]
        bit_count <= bit_count + 5'd1;
        if (bit_count == `TBM_FRAME_ALL_BITS - 5'd1)
        begin
          bit_count <= 5'd0;
          push_pending <= 1'b1;
        end
      end
    end
  end

  // ***************************************************
  // Write buffer toward program memory
  // ***************************************************
  tbm_fifo #(
    .WIDTH(`TBM_FIFO_WIDTH),
    .DEPTH(`TBM_FIFO_DEPTH),
    .AW(`TBM_FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push_pending),
    .in_ready(fifo_ready),
    .in_data(shift_in[26:0]),
    .out_valid(pm_prog_wr),
    .out_ready(pm_prog_ready),
    .out_data(fifo_out)
  );

  assign pm_prog_addr = fifo_out[26:16];
  assign pm_prog_data = fifo_out[15:0];

endmodule
`default_nettype wire

/* verification/tbm_pmem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Program memory partner
// ****
module tbm_pmem_model (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic [10:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire logic pm_prog_wr,
  input wire logic [10:0] pm_prog_addr,
  input wire logic [15:0] pm_prog_data,
  output logic pm_prog_ready,
  output int wr_cnt
);
  logic [15:0] mem [0:2047];
  logic tick = 1'h0;
  int n_wr = 0;
  assign wr_cnt = n_wr;
  // Page number shows in the high byte so a wrong page is caught
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = {5'h1A, i[10:8], i[7:0] ^ 8'h5A};
  end
  // Accepts every other cycle, never while stalled
  assign pm_prog_ready = !stall && tick;
  // One register stage: word is ready at the second edge
  always @(posedge sys_clk)
  begin
    tick <= ~tick;
    pm_rdata <= mem[pm_addr];
    if (pm_prog_wr && pm_prog_ready)
    begin
      mem[pm_prog_addr] <= pm_prog_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

/* verification/tbm_table_mem_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module tbm_table_mem_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tab_start,
  input wire logic tab_last_page,
  input wire logic tab_busy,
  input wire logic tab_done,
  input wire logic [10:0] pm_addr,
  input wire logic pm_prog_wr,
  input wire logic [10:0] pm_prog_addr,
  input wire logic [15:0] pm_prog_data,
  input wire logic pm_prog_ready,
  input wire logic external_reset_n,
  input wire logic prog_data_pin_oe,
  input wire logic prog_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Start taken only when idle and not programming
  sequence s_take;
    tab_start && !tab_busy && !prog_mode;
  endsequence
  // Two busy cycles, then done as busy drops
  sequence s_two_busy;
    tab_busy ##1 tab_busy ##1 (!tab_busy && tab_done);
  endsequence
  a_tab_two_cycles: assert property (s_take |=> s_two_busy)
    else $error("table read length wrong");
  a_done_single: assert property (tab_done |=> !tab_done)
    else $error("done longer than one cycle");
  a_last_page_addr: assert property
    ((s_take and tab_last_page) |=> pm_addr[10:8] == 3'h7)
    else $error("last page bits wrong");
  a_addr_held: assert property
    (tab_busy && $past(tab_busy) |-> $stable(pm_addr))
    else $error("table address moved");
  a_mode_enter: assert property
    (!external_reset_n [*6] |=> prog_mode)
    else $error("programming mode not entered");
  a_mode_leave: assert property
    (external_reset_n [*6] |=> !prog_mode)
    else $error("programming mode not left");
  a_oe_word: assert property
    ($rose(prog_data_pin_oe) |-> prog_data_pin_oe [*8])
    else $error("data pin drive too short");
  a_wr_held: assert property
    (pm_prog_wr && !pm_prog_ready |=> pm_prog_wr &&
      $stable(pm_prog_addr) && $stable(pm_prog_data))
    else $error("held write changed");
endmodule
bind tbm_table_mem tbm_table_mem_sva tbm_table_mem_sva_i (
  .sys_clk, .reset, .tab_start, .tab_last_page, .tab_busy, .tab_done,
  .pm_addr, .pm_prog_wr, .pm_prog_addr, .pm_prog_data, .pm_prog_ready,
  .external_reset_n, .prog_data_pin_oe, .prog_mode
);
`default_nettype wire

/* verification/tbm_table_mem_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench top
// ****
module tbm_table_mem_tb_top;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] dm_addr = 8'h00;
  logic [7:0] dm_wdata = 8'h00;
  logic [7:0] tab_dest = 8'h00;
  logic [2:0] dm_bit_sel = 3'h0;
  logic dm_rd = 1'h0, dm_wr = 1'h0, dm_bit_set = 1'h0, dm_bit_clr = 1'h0;
  logic tab_start = 1'h0, tab_last_page = 1'h0, stall = 1'h0;
  logic external_reset_n = 1'h1, prog_clock_pin = 1'h0, pd_tb = 1'h0;
  logic [7:0] dm_rdata;
  logic [10:0] pm_addr, pm_prog_addr;
  logic [15:0] pm_rdata, pm_prog_data, q;
  logic tab_busy, tab_done, pm_prog_wr, pm_prog_ready, prog_mode;
  logic prog_data_pin_in, prog_data_pin_out, prog_data_pin_oe, prog_busy;
  int error_cnt = 0;
  int checks = 0;
  int wr_cnt;
  // Shared data line: device wins while it drives
  assign prog_data_pin_in = prog_data_pin_oe ? prog_data_pin_out : pd_tb;
  tbm_table_mem tbm_table_mem_i (.sys_clk, .reset, .dm_addr, .dm_rd,
    .dm_wr, .dm_wdata, .dm_bit_set, .dm_bit_clr, .dm_bit_sel, .dm_rdata,
    .tab_start, .tab_last_page, .tab_dest, .tab_busy, .tab_done, .pm_addr,
    .pm_rdata, .pm_prog_wr, .pm_prog_addr, .pm_prog_data, .pm_prog_ready,
    .external_reset_n, .prog_clock_pin, .prog_data_pin_in,
    .prog_data_pin_out, .prog_data_pin_oe, .prog_mode, .prog_busy);
  tbm_pmem_model tbm_pmem_model_i (.sys_clk, .stall, .pm_addr, .pm_rdata,
    .pm_prog_wr, .pm_prog_addr, .pm_prog_data, .pm_prog_ready, .wr_cnt);
  // Clock
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] pw(input logic [10:0] a);
    return {5'h1A, a[10:8], a[7:0] ^ 8'h5A};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    dm_addr = a;
    dm_wdata = d;
    dm_wr = 1'h1;
    @(negedge sys_clk);
    dm_wr = 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    dm_addr = a;
    dm_rd = 1'h1;
    @(negedge sys_clk);
    dm_rd = 1'h0;
    chk(dm_rdata, e);
  endtask
  task automatic bop(input logic [7:0] a, input logic [2:0] b, input logic s);
    @(negedge sys_clk);
    dm_addr = a;
    dm_bit_sel = b;
    dm_bit_set = s;
    dm_bit_clr = !s;
    @(negedge sys_clk);
    dm_bit_set = 1'h0;
    dm_bit_clr = 1'h0;
  endtask
  // Table read; done must land on the third cycle after the start edge
  task automatic tab(input logic lp, input logic [2:0] pg,
    input logic [7:0] p, input logic [7:0] d, input logic [15:0] w);
    wr(8'h07, p);
    wr(8'h1F, {5'h00, pg});
    @(negedge sys_clk);
    tab_start = 1'h1;
    tab_last_page = lp;
    tab_dest = d;
    @(negedge sys_clk);
    tab_start = 1'h0;
    chk(tab_busy, 1'h1);
    repeat (2) @(negedge sys_clk);
    chk(tab_done, 1'h1);
    chk(pm_addr, {lp ? 3'h7 : pg, p});
    rdc(d, w[7:0]);
    rdc(8'h08, w[15:8]);
  endtask
  // Serial frame, MSB first; link clock idles low between frames
  task automatic frame(input logic r, input logic [10:0] a,
    input logic [15:0] d);
    logic [27:0] f;
    f = {r, a, d};
    for (int i = 27; i >= 0; i--)
    begin
      pd_tb = (r && i < 16) ? ~pd_tb : f[i];
      #32 prog_clock_pin = 1'h1;
      q[i % 16] = prog_data_pin_in;
      #32 prog_clock_pin = 1'h0;
    end
  endtask
  task automatic t_dm;
    wr(8'h30, 8'hA5);
    wr(8'hFF, 8'h3C);
    rdc(8'h30, 8'hA5);
    rdc(8'hFF, 8'h3C);
    bop(8'h30, 3'h0, 1'h0);
    bop(8'h30, 3'h6, 1'h1);
    rdc(8'h30, 8'hE4);
    wr(8'h02, 8'h55);
    bop(8'h2F, 3'h1, 1'h1);
    rdc(8'h02, 8'h00);
    rdc(8'h2F, 8'h00);
    wr(8'h1F, 8'hFA);
    rdc(8'h1F, 8'h02);
    wr(8'h01, 8'h40);
    wr(8'h00, 8'h6B);
    rdc(8'h40, 8'h6B);
    rdc(8'h00, 8'h6B);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h12);
    rdc(8'h00, 8'h00);
    $display("t_dm done");
  endtask
  task automatic t_table;
    tab(1'h1, 3'h2, 8'h06, 8'h50, pw(11'h706));
    tab(1'h0, 3'h5, 8'h05, 8'h51, pw(11'h505));
    wr(8'h08, 8'h00);
    rdc(8'h08, 8'hD5);
    $display("t_table done");
  endtask
  // Core port writes are refused while the pin holds programming mode
  task automatic t_prog;
    wr(8'h31, 8'h11);
    external_reset_n = 1'h0;
    repeat (8) @(negedge sys_clk);
    chk(prog_mode, 1'h1);
    chk(prog_data_pin_oe, 1'h0);
    wr(8'h31, 8'h99);
    frame(1'h0, 11'h123, 16'hBEEF);
    repeat (8) @(negedge sys_clk);
    frame(1'h1, 11'h123, 16'h0000);
    chk(q, 16'hBEEF);
    external_reset_n = 1'h1;
    repeat (8) @(negedge sys_clk);
    rdc(8'h31, 8'h11);
    tab(1'h0, 3'h1, 8'h23, 8'h32, 16'hBEEF);
    $display("t_prog done");
  endtask
  // Stalled far side: 17 words fill FIFO and its output stage, 18th waits
  task automatic t_fifo;
    int c0;
    int n;
    c0 = wr_cnt;
    stall = 1'h1;
    external_reset_n = 1'h0;
    repeat (8) @(negedge sys_clk);
    for (int i = 0; i < 18; i++)
      frame(1'h0, 11'h200 + i[10:0], 16'h1000 + i[15:0]);
    repeat (8) @(negedge sys_clk);
    chk(prog_busy, 1'h1);
    stall = 1'h0;
    for (n = 0; n < 400 && wr_cnt != c0 + 18; n++)
      @(negedge sys_clk);
    if (n == 400)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: write drain timed out", $time);
      wrap_up();
    end
    chk(prog_busy, 1'h0);
    frame(1'h1, 11'h210, 16'h0000);
    chk(q, 16'h1010);
    external_reset_n = 1'h1;
    $display("t_fifo done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(negedge sys_clk);
    reset = 1'h0;
    t_dm();
    t_table();
    t_prog();
    t_fifo();
    wrap_up();
  end
endmodule
`default_nettype wire
